// [core/lf_osc_sync.sv]
// Purpose: brings oscillator output and ready level into the core clock
// Assumes: both inputs asynchronous to i_core_clk
// Notes:   a change counts once stages two and three agree
`timescale 1ns/100ps
module lf_osc_sync (
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	// raw oscillator side
	input  wire logic i_lf_osc_raw,
	input  wire logic i_lf_ready_raw,
	// synchronised view
	lf_edge_if.src    edges
);
	import osc_ctl_pkg::*;

	typedef struct packed {
		logic [SYNC_BITS-1:0] st1;
		logic [SYNC_BITS-1:0] st2;
		logic [SYNC_BITS-1:0] st3;
		logic [SYNC_BITS-1:0] stable;
		logic                 rise;
		logic                 fall;
	} sync_t;

	sync_t q;
	sync_t next_q;
	logic [SYNC_BITS-1:0] agree;

	////////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_BITS; gi++) begin : g_agree
			assign agree[gi] = q.st2[gi] == q.st3[gi];
		end
	endgenerate

	always_comb begin
		next_q     = q;
		next_q.st1 = {i_lf_ready_raw, i_lf_osc_raw};
		next_q.st2 = q.st1;
		next_q.st3 = q.st2;
		for (int b = 0; b < SYNC_BITS; b++) begin
			if (agree[b]) begin
				next_q.stable[b] = q.st2[b];
			end
		end
		next_q.rise = agree[SYNC_LEVEL] && q.st2[SYNC_LEVEL] && !q.stable[SYNC_LEVEL];
		next_q.fall = agree[SYNC_LEVEL] && !q.st2[SYNC_LEVEL] && q.stable[SYNC_LEVEL];
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign edges.level = q.stable[SYNC_LEVEL];
	assign edges.ready = q.stable[SYNC_READY];
	assign edges.rise  = q.rise;
	assign edges.fall  = q.fall;

	////////////////////////////////////////////////////////////////////////
	sync_rise_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		q.rise |-> q.stable[SYNC_LEVEL] && !$past(q.stable[SYNC_LEVEL]))
		else $error("rise pulse without a settled level change");
endmodule : lf_osc_sync

// [core/osc_calibration_and_lf_divider.sv]
// Purpose: oscillator calibration registers, low-frequency divider, capture events
// Assumes: single-cycle register strobes on i_core_clk, factory trims held stable
// Notes:   analog oscillators and timers live outside this block
//
// What this block does
// - five low calibration bits set high-frequency period; zero fastest, ones slowest
// - calibration register loads the per-part factory trim after reset
// - calibration readback is undefined while usb clock recovery runs
// - low-frequency oscillator runs nominally at 80 kHz before the divider
// - divider select bits 1:0: 00 by 8, 01 by 4, 10 by 2, 11 by 1
// - fine-tune bits 5:2 set low-frequency speed, 0000 fastest
// - fine-tune value 1111 gives the slowest low-frequency setting
// - control bit 7 enables the low-frequency oscillator
// - control bit 6 is read-only ready flag, set once stabilised
// - in capture mode timer 2 captures falling edges, timer 3 rising
// - a capture copies the 16-bit timer count into its reload pair
// - system clock may come from either internal oscillator or others
`timescale 1ns/100ps
module osc_calibration_and_lf_divider (
	// clock and reset
	input  wire logic                              i_core_clk,
	input  wire logic                              i_rst_n,
	// special function register port
	input  wire logic [osc_ctl_pkg::SFR_AW-1:0]    i_sfr_addr,
	input  wire logic [osc_ctl_pkg::SFR_DW-1:0]    i_sfr_wdata,
	input  wire logic                              i_sfr_wr,
	input  wire logic                              i_sfr_rd,
	output logic      [osc_ctl_pkg::SFR_DW-1:0]    o_sfr_rdata,
	// factory trims and status from the analog side
	input  wire logic [osc_ctl_pkg::HF_TRIM_W-1:0] i_hf_factory_trim,
	input  wire logic [osc_ctl_pkg::LF_TRIM_W-1:0] i_lf_factory_trim,
	input  wire logic                              i_usb_clk_recovery_en,
	input  wire logic                              i_lf_osc_raw,
	input  wire logic                              i_lf_ready_raw,
	// oscillator controls
	output logic      [osc_ctl_pkg::HF_TRIM_W-1:0] o_hf_period_trim,
	output logic                                   o_lf_osc_enable,
	output logic      [osc_ctl_pkg::LF_TRIM_W-1:0] o_lf_freq_trim,
	output logic                                   o_lf_div_out,
	// system clock source
	input  wire logic [1:0]                        i_system_clock_select,
	output logic      [1:0]                        o_system_clock_select,
	// timer capture
	input  wire logic                              i_t2_lf_capture_mode,
	input  wire logic                              i_t3_lf_capture_mode,
	input  wire logic [osc_ctl_pkg::TIMER_W-1:0]   i_t2_count,
	input  wire logic [osc_ctl_pkg::TIMER_W-1:0]   i_t3_count,
	output logic                                   o_t2_capture,
	output logic                                   o_t3_capture,
	output logic      [osc_ctl_pkg::TIMER_W-1:0]   o_t2_reload,
	output logic      [osc_ctl_pkg::TIMER_W-1:0]   o_t3_reload
);
	import osc_ctl_pkg::*;

	typedef struct packed {
		logic                 loaded;
		logic [HF_TRIM_W-1:0] hf_trim;
		logic                 lf_en;
		logic [LF_TRIM_W-1:0] lf_trim;
		logic [LF_DIV_W-1:0]  lf_div;
		logic [1:0]           div_cnt;
		logic                 lf_out;
		logic [SFR_DW-1:0]    rdata;
		logic [1:0]           clk_sel;
		logic                 t2_cap;
		logic                 t3_cap;
		logic [TIMER_W-1:0]   t2_rl;
		logic [TIMER_W-1:0]   t3_rl;
	} osc_state_t;

	osc_state_t q;
	osc_state_t next_q;
	lf_edge_if  lf_view ();

	logic             wr_hf;
	logic             wr_lf;
	logic             lf_ready;
	logic [1:0]       div_mask;
	logic [SFR_DW-1:0] lf_word;

	////////////////////////////////////////////////////////////////////////
	lf_osc_sync u_lf_sync (
		.i_core_clk     (i_core_clk),
		.i_rst_n        (i_rst_n),
		.i_lf_osc_raw   (i_lf_osc_raw),
		.i_lf_ready_raw (i_lf_ready_raw),
		.edges          (lf_view.src)
	);

	////////////////////////////////////////////////////////////////////////
	assign wr_hf    = i_sfr_wr && (i_sfr_addr == ADDR_HF_CAL);
	assign wr_lf    = i_sfr_wr && (i_sfr_addr == ADDR_LF_CTRL);
	// a stopped oscillator never reports ready, whatever the analog flag says
	assign lf_ready = lf_view.ready && q.lf_en;

	always_comb begin
		lf_word              = '0;
		lf_word[LF_EN_BIT]   = q.lf_en;
		lf_word[LF_RDY_BIT]  = lf_ready;
		lf_word[LF_TRIM_LSB +: LF_TRIM_W] = q.lf_trim;
		lf_word[LF_DIV_LSB +: LF_DIV_W]   = q.lf_div;
	end

	// number of rising edges between output toggles, minus one
	always_comb begin
		case (q.lf_div)
			LF_DIV_8: div_mask = 2'h3;
			LF_DIV_4: div_mask = 2'h1;
			LF_DIV_2: div_mask = 2'h0;
			default:  div_mask = 2'h0;
		endcase
	end

	always_comb begin
		next_q        = q;
		next_q.t2_cap = 1'b0;
		next_q.t3_cap = 1'b0;
		// factory trims land on the first edge after reset release
		if (!q.loaded) begin
			next_q.loaded  = 1'b1;
			next_q.hf_trim = i_hf_factory_trim;
			next_q.lf_trim = i_lf_factory_trim;
		end
		if (wr_hf) begin
			next_q.hf_trim = i_sfr_wdata[HF_TRIM_LSB +: HF_TRIM_W];
		end
		if (wr_lf) begin
			next_q.lf_en   = i_sfr_wdata[LF_EN_BIT];
			next_q.lf_trim = i_sfr_wdata[LF_TRIM_LSB +: LF_TRIM_W];
			next_q.lf_div  = i_sfr_wdata[LF_DIV_LSB +: LF_DIV_W];
		end
		// divider on the synchronised oscillator; halted while disabled
		if (!q.lf_en) begin
			next_q.div_cnt = '0;
			next_q.lf_out  = 1'b0;
		end else if (q.lf_div == LF_DIV_1) begin
			next_q.div_cnt = '0;
			next_q.lf_out  = lf_view.level;
		end else if (lf_view.rise) begin
			if ((q.div_cnt & div_mask) == div_mask) begin
				next_q.div_cnt = '0;
				next_q.lf_out  = !q.lf_out;
			end else begin
				next_q.div_cnt = q.div_cnt + 2'h1;
			end
		end
		// capture on edges of the divided output
		if (q.lf_en && i_t2_lf_capture_mode && q.lf_out && !next_q.lf_out) begin
			next_q.t2_cap = 1'b1;
			next_q.t2_rl  = i_t2_count;
		end
		if (q.lf_en && i_t3_lf_capture_mode && !q.lf_out && next_q.lf_out) begin
			next_q.t3_cap = 1'b1;
			next_q.t3_rl  = i_t3_count;
		end
		// refuse a switch onto the low-frequency source until it is ready
		if (i_system_clock_select != CLK_SRC_LF || lf_ready) begin
			next_q.clk_sel = i_system_clock_select;
		end
		if (i_sfr_rd) begin
			case (i_sfr_addr)
				// stored trim is returned; recovery may make it meaningless
				ADDR_HF_CAL:  next_q.rdata = {{(SFR_DW-HF_TRIM_W){1'b0}}, q.hf_trim};
				ADDR_LF_CTRL: next_q.rdata = lf_word;
				default:      next_q.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q         <= '0;
			q.hf_trim <= HF_TRIM_FAST;
			q.lf_trim <= LF_TRIM_FAST;
			q.lf_en   <= LF_EN_RESET;
			q.lf_div  <= LF_DIV_RESET;
			q.clk_sel <= CLK_SRC_HF;
		end else begin
			q <= next_q;
		end
	end

	assign o_sfr_rdata      = q.rdata;
	assign o_hf_period_trim = q.hf_trim;
	assign o_lf_osc_enable  = q.lf_en;
	assign o_lf_freq_trim   = q.lf_trim;
	assign o_lf_div_out     = q.lf_out;
	assign o_system_clock_select  = q.clk_sel;
	assign o_t2_capture     = q.t2_cap;
	assign o_t3_capture     = q.t3_cap;
	assign o_t2_reload      = q.t2_rl;
	assign o_t3_reload      = q.t3_rl;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence hf_write_s;
		wr_hf && q.loaded;
	endsequence

	sequence lf_fall_s;
		$fell(o_lf_div_out) && $past(q.lf_en);
	endsequence

	sequence lf_rise_s;
		$rose(o_lf_div_out) && $past(q.lf_en);
	endsequence

	hf_trim_write_a: assert property (
		hf_write_s |=> o_hf_period_trim == $past(i_sfr_wdata[HF_TRIM_LSB +: HF_TRIM_W]))
		else $error("calibration write not applied");

	factory_load_a: assert property (
		$rose(q.loaded) && !$past(wr_hf) |-> o_hf_period_trim == $past(i_hf_factory_trim))
		else $error("factory trim not loaded after reset");

	lf_fields_a: assert property (
		wr_lf |=> o_lf_freq_trim == $past(i_sfr_wdata[LF_TRIM_LSB +: LF_TRIM_W]) &&
		o_lf_osc_enable == $past(i_sfr_wdata[LF_EN_BIT]))
		else $error("low-frequency control write not applied");

	lf_off_a: assert property (
		!o_lf_osc_enable |=> !o_lf_div_out ##1 !o_lf_div_out or o_lf_osc_enable)
		else $error("divided output runs while disabled");

	div_pass_a: assert property (
		o_lf_osc_enable && q.lf_div == LF_DIV_1 && !wr_lf |=> o_lf_div_out == $past(lf_view.level))
		else $error("divide by one does not follow oscillator");

	div_two_a: assert property (
		o_lf_osc_enable && q.lf_div == LF_DIV_2 && lf_view.rise && !wr_lf |=> $changed(o_lf_div_out))
		else $error("divide by two missed a toggle");

	ready_read_a: assert property (
		i_sfr_rd && i_sfr_addr == ADDR_LF_CTRL |=> o_sfr_rdata[LF_RDY_BIT] == $past(lf_view.ready && q.lf_en))
		else $error("ready flag readback wrong");

	t2_capture_a: assert property (
		o_t2_capture |-> lf_fall_s and $past(i_t2_lf_capture_mode))
		else $error("timer 2 capture not on falling edge");

	t3_capture_a: assert property (
		o_t3_capture |-> lf_rise_s and $past(i_t3_lf_capture_mode))
		else $error("timer 3 capture not on rising edge");

	capture_copy_a: assert property (
		(lf_fall_s and $past(i_t2_lf_capture_mode)) |-> o_t2_capture && o_t2_reload == $past(i_t2_count))
		else $error("timer 2 count not copied on capture");

	clk_select_a: assert property (
		$changed(o_system_clock_select) && o_system_clock_select == CLK_SRC_LF |-> $past(lf_ready))
		else $error("switched to low-frequency clock before ready");

	t3_copy_a: assert property (
		(lf_rise_s and $past(i_t3_lf_capture_mode)) |->
		o_t3_capture && o_t3_reload == $past(i_t3_count))
		else $error("timer 3 count not copied on capture");

	// reloads only move on a capture, so software can difference them at leisure
	t2_reload_hold_a: assert property (
		!o_t2_capture |-> $stable(o_t2_reload))
		else $error("timer 2 reload moved without a capture");

	t3_reload_hold_a: assert property (
		!o_t3_capture |-> $stable(o_t3_reload))
		else $error("timer 3 reload moved without a capture");

	t2_pulse_a: assert property (
		o_t2_capture |=> !o_t2_capture)
		else $error("timer 2 capture longer than one cycle");

	t3_pulse_a: assert property (
		o_t3_capture |=> !o_t3_capture)
		else $error("timer 3 capture longer than one cycle");

	div_quiet_a: assert property (
		o_lf_osc_enable && q.lf_div != LF_DIV_1 && !lf_view.rise |=> $stable(o_lf_div_out))
		else $error("divided output toggled without an oscillator edge");

	rdata_hold_a: assert property (
		!i_sfr_rd |=> $stable(o_sfr_rdata))
		else $error("read data changed without a read");

	hf_read_a: assert property (
		i_sfr_rd && i_sfr_addr == ADDR_HF_CAL |=>
		o_sfr_rdata == {{(SFR_DW-HF_TRIM_W){1'b0}}, $past(o_hf_period_trim)})
		else $error("calibration readback wrong");

	lf_read_a: assert property (
		i_sfr_rd && i_sfr_addr == ADDR_LF_CTRL |=>
		o_sfr_rdata[LF_TRIM_LSB +: LF_TRIM_W] == $past(o_lf_freq_trim) &&
		o_sfr_rdata[LF_EN_BIT] == $past(o_lf_osc_enable))
		else $error("low-frequency control readback wrong");

	// stored trim stays put under clock recovery; only a write moves it
	recovery_trim_a: assert property (
		i_usb_clk_recovery_en && q.loaded && !wr_hf |=> $stable(o_hf_period_trim))
		else $error("calibration trim moved under clock recovery");

	lf_hold_a: assert property (
		q.loaded && !wr_lf |=> $stable(o_lf_osc_enable) && $stable(o_lf_freq_trim))
		else $error("low-frequency control moved without a write");

	sel_hold_a: assert property (
		i_system_clock_select == CLK_SRC_LF && !lf_ready |=> $stable(o_system_clock_select))
		else $error("clock source switched onto an unready oscillator");

	sel_follow_a: assert property (
		i_system_clock_select != CLK_SRC_LF |=> o_system_clock_select == $past(i_system_clock_select))
		else $error("clock source request not applied");
endmodule : osc_calibration_and_lf_divider

// [inc/lf_edge_if.sv]
// Purpose: carries the synchronised low-frequency oscillator view
// Assumes: all signals in the core clock domain
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/100ps
interface lf_edge_if;
	logic level;
	logic rise;
	logic fall;
	logic ready;
	modport src  (output level, output rise, output fall, output ready);
	modport sink (input level, input rise, input fall, input ready);
endinterface : lf_edge_if

// [inc/osc_ctl_pkg.sv]
// Purpose: shared constants for the oscillator control block
// Assumes: 8-bit special function register port, 25 MHz core clock
// Notes:   reset values that come from factory trim are inputs, not constants
package osc_ctl_pkg;
	localparam int          SFR_AW          = 8;
	localparam int          SFR_DW          = 8;
	localparam logic [7:0]  ADDR_LF_CTRL    = 8'h86;
	localparam logic [7:0]  ADDR_HF_CAL     = 8'hB3;
	// high-frequency calibration layout
	localparam int          HF_TRIM_W       = 5;
	localparam int          HF_TRIM_LSB     = 0;
	localparam logic [4:0]  HF_TRIM_FAST    = 5'h00;
	localparam logic [4:0]  HF_TRIM_SLOW    = 5'h1F;
	// low-frequency control layout
	localparam int          LF_EN_BIT       = 7;
	localparam int          LF_RDY_BIT      = 6;
	localparam int          LF_TRIM_LSB     = 2;
	localparam int          LF_TRIM_W       = 4;
	localparam int          LF_DIV_LSB      = 0;
	localparam int          LF_DIV_W        = 2;
	localparam logic [3:0]  LF_TRIM_FAST    = 4'h0;
	localparam logic [3:0]  LF_TRIM_SLOW    = 4'hF;
	localparam logic        LF_EN_RESET     = 1'h0;
	localparam logic [1:0]  LF_DIV_RESET    = 2'h0;
	// divider select codes
	localparam logic [1:0]  LF_DIV_8        = 2'h0;
	localparam logic [1:0]  LF_DIV_4        = 2'h1;
	localparam logic [1:0]  LF_DIV_2        = 2'h2;
	localparam logic [1:0]  LF_DIV_1        = 2'h3;
	localparam int          LF_NOMINAL_KHZ  = 80;
	// system clock source codes
	localparam logic [1:0]  CLK_SRC_HF      = 2'h0;
	localparam logic [1:0]  CLK_SRC_LF      = 2'h1;
	localparam logic [1:0]  CLK_SRC_EXT     = 2'h2;
	localparam logic [1:0]  CLK_SRC_MULT    = 2'h3;
	localparam int          TIMER_W         = 16;
	localparam int          SYNC_BITS       = 2;
	localparam int          SYNC_LEVEL      = 0;
	localparam int          SYNC_READY      = 1;
endpackage : osc_ctl_pkg

// [sim/osc_calibration_and_lf_divider_tb.sv]
// Purpose: self-checking bench for the oscillator control block
// Assumes: 25 MHz core clock, task inputs driven 1 ns after the rising edge, raw oscillator and counts on the edge
// Notes:   raw oscillator is a 16-cycle square wave made here
`timescale 1ns/100ps
module osc_calibration_and_lf_divider_tb;
	import osc_ctl_pkg::*;
	localparam logic [4:0] HF_FAC = 5'h15;
	localparam logic [3:0] LF_FAC = 4'h9;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] rd;
		logic [4:0] hf;
		logic [4:0] lf;
	} row_t;
	row_t rows [7] = '{
		'{8'hB3, 8'hFF, 8'h1F, 5'h1F, {1'b0, LF_FAC}},
		'{8'hB3, 8'hE0, 8'h00, 5'h00, {1'b0, LF_FAC}},
		'{8'h86, 8'h83, 8'h83, 5'h00, 5'h10},
		'{8'h86, 8'h3C, 8'h3C, 5'h00, 5'h0F},
		'{8'h86, 8'hC1, 8'h81, 5'h00, 5'h10},
		'{8'h55, 8'hFF, 8'h00, 5'h00, 5'h10},
		'{8'h86, 8'hC2, 8'h82, 5'h00, 5'h10}};
	logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic        usb_en = 1'b0, osc_raw = 1'b0, rdy_raw = 1'b0;
	logic        m2 = 1'b0, m3 = 1'b0, lf_en, div_out, cap2, cap3;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, v;
	logic [4:0]  hf_trim;
	logic [3:0]  lf_trim;
	logic [1:0]  sel_in = 2'h0, sel_out;
	logic [2:0]  ph = 3'h0;
	logic [15:0] cnt = 16'h0000, t3cnt, rl2, rl3, r1, r2;
	int          n_errors = 0, checked = 0, hits;
	assign t3cnt = cnt + 16'h1000;
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cnt <= cnt + 16'h0001;
		ph <= ph + 3'h1;
		if (ph == 3'h7)
			osc_raw <= ~osc_raw;
	end
	osc_calibration_and_lf_divider i_dut (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
		.i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
		.i_hf_factory_trim(HF_FAC), .i_lf_factory_trim(LF_FAC),
		.i_usb_clk_recovery_en(usb_en), .i_lf_osc_raw(osc_raw), .i_lf_ready_raw(rdy_raw),
		.o_hf_period_trim(hf_trim), .o_lf_osc_enable(lf_en), .o_lf_freq_trim(lf_trim),
		.o_lf_div_out(div_out), .i_system_clock_select(sel_in), .o_system_clock_select(sel_out),
		.i_t2_lf_capture_mode(m2), .i_t3_lf_capture_mode(m3),
		.i_t2_count(cnt), .i_t3_count(t3cnt), .o_t2_capture(cap2), .o_t3_capture(cap3),
		.o_t2_reload(rl2), .o_t3_reload(rl3));
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
	endtask : sfr_wr
	task automatic sfr_rd(input logic [7:0] a);
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		v = rdata;
	endtask : sfr_rd
	// waits for one capture pulse; the reload must hold the count of the cycle before
	task automatic wait_cap(input logic t3, output logic [15:0] rl);
		int i;
		for (i = 0; i < 400 && (t3 ? cap3 : cap2) !== 1'b1; i++)
			tick(1);
		if (i == 400) begin
			n_errors++;
			give_verdict();
		end
		check(div_out, t3);
		rl = t3 ? rl3 : rl2;
		check(rl, (t3 ? t3cnt : cnt) - 16'h0001);
		tick(1);
	endtask : wait_cap
	////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(12);
		rst_n = 1'b1;
		tick(2);
		foreach (rows[k]) begin
			sfr_wr(rows[k].a, rows[k].d);
			sfr_rd(rows[k].a);
			check(v, rows[k].rd);
			check(hf_trim, rows[k].hf);
			check({lf_en, lf_trim}, rows[k].lf);
		end
		// second reset in mid-run: outputs clear, then factory trims load
		rst_n = 1'b0;
		tick(2);
		check({hf_trim, lf_en, lf_trim, div_out, sel_out}, 16'h0000);
		rst_n = 1'b1;
		tick(2);
		check(hf_trim, HF_FAC);
		sfr_rd(ADDR_HF_CAL);
		check(v, {3'h0, HF_FAC});
		// readback is left unchecked while recovery runs, the trim output is not
		usb_en = 1'b1;
		sfr_wr(ADDR_HF_CAL, 8'h0A);
		check(hf_trim, 5'h0A);
		usb_en = 1'b0;
		tick(1);
		// switching to the low-frequency source waits for ready
		sfr_wr(ADDR_LF_CTRL, 8'h83);
		sel_in = CLK_SRC_LF;
		tick(3);
		check(sel_out, CLK_SRC_HF);
		rdy_raw = 1'b1;
		tick(8);
		sfr_rd(ADDR_LF_CTRL);
		check(v, 8'hC3);
		check(sel_out, CLK_SRC_LF);
		sel_in = CLK_SRC_EXT;
		tick(2);
		check(sel_out, CLK_SRC_EXT);
		// capture spacing gives the divide ratio: 16 cycles per raw period
		m2 = 1'b1;
		m3 = 1'b1;
		for (int k = 0; k < 4; k++) begin
			sfr_wr(ADDR_LF_CTRL, {2'b10, 4'h5, 2'(k)});
			tick(40);
			wait_cap(1'b1, r1);
			wait_cap(1'b1, r2);
			check(r2 - r1, 16'd16 << (3 - k));
			wait_cap(1'b0, r1);
			wait_cap(1'b0, r2);
			check(r2 - r1, 16'd16 << (3 - k));
		end
		// no capture outside capture mode
		m2 = 1'b0;
		m3 = 1'b0;
		hits = 0;
		repeat (200) begin
			tick(1);
			hits += int'(cap2 === 1'b1 || cap3 === 1'b1);
		end
		check(16'(hits), 16'h0000);
		// disabling stops the output and hides ready
		sfr_wr(ADDR_LF_CTRL, 8'h03);
		sfr_rd(ADDR_LF_CTRL);
		check(v, 8'h03);
		hits = 0;
		repeat (100) begin
			tick(1);
			hits += int'(div_out !== 1'b0);
		end
		check(16'(hits), 16'h0000);
		give_verdict();
	end
endmodule : osc_calibration_and_lf_divider_tb
